// ===== lsx_pkg.sv
// Package for the load, store and shift execution block.
// Holds opcodes, flag positions, field widths and the condition code width and count.
// Assumes one clock domain and a word-wide integer datapath.
package lsx_pkg;

    // Word and register widths.
    localparam int DW = 32;
    localparam int XW = 40;
    localparam int EXP_LO = 32;
    localparam int EXP_HI = 39;
    localparam int MAN_HI = 31;
    localparam int FMAN_LO = 8; // Lowest mantissa bit a memory float fills.
    localparam int REGS_N = 28;
    localparam int REG_AW = 5;
    localparam int EXT_REGS_N = 8;
    localparam int CNT_W = 7;
    localparam int SHAMT_W = 6;
    localparam int COND_W = 5;
    localparam int COND_N = 20;

    // Register file indices of special registers.
    localparam logic [REG_AW-1:0] REG_IDX0 = 5'h11;
    localparam logic [REG_AW-1:0] REG_IDX1 = 5'h12;
    localparam logic [REG_AW-1:0] REG_DPAGE = 5'h10;
    localparam logic [REG_AW-1:0] REG_STATUS = 5'h15;

    // Status flag bit positions.
    localparam int F_C = 0;
    localparam int F_V = 1;
    localparam int F_Z = 2;
    localparam int F_N = 3;
    localparam int F_UF = 4;
    localparam int F_LV = 5;
    localparam int F_LUF = 6;
    localparam int FLAGS_W = 7;

    // Source addressing modes.
    localparam logic [1:0] AM_REG = 2'h0;
    localparam logic [1:0] AM_DIR = 2'h1;
    localparam logic [1:0] AM_IND = 2'h2;
    localparam logic [1:0] AM_IMM = 2'h3;

    // Indirect displacement selections for the parallel forms.
    localparam logic [1:0] DISP_0 = 2'h0;
    localparam logic [1:0] DISP_1 = 2'h1;
    localparam logic [1:0] DISP_IR0 = 2'h2;
    localparam logic [1:0] DISP_IR1 = 2'h3;

    // Operations executed by this block.
    typedef enum logic [3:0] {
        LSX_NOP, LSX_ILOAD, LSX_ILOAD_C, LSX_ILOAD_U, LSX_ILOAD_I,
        LSX_ILOAD2, LSX_ILOAD_ST, LSX_FLOAD_ST, LSX_MLOAD, LSX_LSHIFT
    } lsx_op_t;

    // Execute-cycle state.
    typedef enum logic [0:0] {ST_IDLE, ST_EXEC} lsx_state_t;

endpackage : lsx_pkg

// ===== lsx_shift.sv
// Logical shifter with carry out for the shift instruction.
// Assumes a purely combinational use inside the execute stage.
`timescale 1ns/100ps
module lsx_shift
    import lsx_pkg::*;
(
    input wire logic [DW-1:0] value,
    input wire logic [DW-1:0] count,
    output logic [DW-1:0] result,
    output logic carry
);

    logic signed [CNT_W-1:0] cnt7;
    logic [CNT_W-1:0] mag;
    logic [2*DW:0] wide;

    // Only the low count bits form the signed shift amount.
    assign cnt7 = signed'(count[CNT_W-1:0]);
    assign mag = cnt7[CNT_W-1] ? CNT_W'(-cnt7) : CNT_W'(cnt7);

    // A widened word keeps the last bit out beside the result.
    always_comb begin
        wide = '0;
        result = value;
        carry = 1'b0;
        if (cnt7 > 0) begin
            // Left: zeros enter low, top bits leave through carry.
            wide = {1'b0, {DW{1'b0}}, value} << mag;
            result = wide[DW-1:0];
            carry = (mag > CNT_W'(DW)) ? 1'b0 : wide[DW];
        end else if (cnt7 < 0) begin
            // Right: zeros enter high, low bits leave through carry.
            wide = {value, 1'b0, {DW{1'b0}}} >> mag;
            result = wide[2*DW:DW+1];
            carry = (mag > CNT_W'(DW)) ? 1'b0 : wide[DW];
        end
        // A zero count keeps the word and clears carry.
    end

endmodule : lsx_shift

// ===== lsx_exec.sv
// Execute stage for loads, parallel load/store, mantissa load and shift.
// Assumes a decoded operation per issue pulse and memory that answers
// reads combinationally; memory writes are issued at the execute end.
//
// Summary of operation
// - Float load and float store together.
// - Same word: old value read first.
// - Parallel operands: indirect, displacement 0/1/index.
// - Conditional load writes only when true.
// - Twenty condition codes from status flags.
// - Unconditional load leaves all flags alone.
// - Interlocked load pulses both flag pins.
// - Interlocked load allows direct, indirect only.
// - Interlocked load sets N Z, clears V UF.
// - Dual load does two register loads.
// - Same target: second source value wins.
// - Integer load and integer store together.
// - Mantissa load keeps the exponent field.
// - Shift count from seven low bits.
// - Positive count shifts left through carry.
// - Negative count shifts right through carry.
// - Zero count: no shift, carry cleared.
// - Shift sets C N Z, clears V UF.
`timescale 1ns/100ps
module lsx_exec
    import lsx_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic ISSUE,
    input wire lsx_op_t OP,
    input wire logic [1:0] SRC_MODE,
    input wire logic [REG_AW-1:0] SRC_REG,
    input wire logic [REG_AW-1:0] DST_REG,
    input wire logic [REG_AW-1:0] DST2_REG,
    input wire logic [REG_AW-1:0] STORE_REG,
    input wire logic [COND_W-1:0] COND,
    input wire logic [DW-1:0] IMM,
    input wire logic [DW-1:0] ADDR_A_BASE,
    input wire logic [1:0] ADDR_A_DISP,
    input wire logic [DW-1:0] ADDR_B_BASE,
    input wire logic [1:0] ADDR_B_DISP,
    input wire logic [DW-1:0] MEM_RDATA_A,
    input wire logic [DW-1:0] MEM_RDATA_B,
    output logic [DW-1:0] MEM_RADDR_A,
    output logic [DW-1:0] MEM_RADDR_B,
    output logic MEM_WE,
    output logic [DW-1:0] MEM_WADDR,
    output logic [DW-1:0] MEM_WDATA,
    output logic XFLAG0_O,
    output logic XFLAG0_OE,
    output logic XFLAG1_O,
    output logic XFLAG1_OE,
    output logic ILLEGAL,
    output logic BUSY,
    output logic [FLAGS_W-1:0] FLAGS,
    output logic [DW-1:0] DPAGE
);

    ////////////////////////////////////////////////////////////////////////
    // Register file and functions.

    logic [XW-1:0] regs_r [REGS_N];
    logic [FLAGS_W-1:0] flags_r;
    lsx_state_t state_r;
    logic illegal_r;
    logic xf_r;
    logic we_r;
    logic [DW-1:0] waddr_r;
    logic [DW-1:0] wdata_r;

    // Indirect address with the limited displacement set.
    function automatic logic [DW-1:0] ind_addr(input logic [DW-1:0] base,
                                               input logic [1:0] disp,
                                               input logic [DW-1:0] ir0,
                                               input logic [DW-1:0] ir1);
        logic [DW-1:0] a;
        a = base;
        unique case (disp)
            DISP_0: a = base;
            DISP_1: a = base + DW'(1);
            DISP_IR0: a = base + ir0;
            DISP_IR1: a = base + ir1;
        endcase
        return a;
    endfunction : ind_addr

    // Twenty condition codes over the status flags.
    function automatic logic cond_true(input logic [COND_W-1:0] c,
                                       input logic [FLAGS_W-1:0] f);
        logic r;
        logic n, z, v, cy, uf, lv, latched_underflow_flag;
        n = f[F_N];
        z = f[F_Z];
        v = f[F_V];
        cy = f[F_C];
        uf = f[F_UF];
        lv = f[F_LV];
        latched_underflow_flag = f[F_LUF];
        r = 1'b0;
        case (c)
            5'h00: r = 1'b1;
            5'h01: r = cy;
            5'h02: r = cy | z;
            5'h03: r = ~cy & ~z;
            5'h04: r = ~cy;
            5'h05: r = z;
            5'h06: r = ~z;
            5'h07: r = n;
            5'h08: r = n | z;
            5'h09: r = ~n & ~z;
            5'h0A: r = ~n;
            5'h0B: r = ~v;
            5'h0C: r = v;
            5'h0D: r = ~uf;
            5'h0E: r = uf;
            5'h0F: r = ~lv;
            5'h10: r = lv;
            5'h11: r = ~latched_underflow_flag;
            5'h12: r = latched_underflow_flag;
            5'h13: r = z | uf;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : cond_true

    ////////////////////////////////////////////////////////////////////////
    // Operand fetch, sampled at the start of the execute cycle.

    logic [XW-1:0] src_val;
    logic [DW-1:0] ir0_v;
    logic [DW-1:0] ir1_v;
    logic [DW-1:0] shift_res;
    logic shift_c;
    logic par_op;
    logic src_bad;

    assign ir0_v = regs_r[REG_IDX0][DW-1:0];
    assign ir1_v = regs_r[REG_IDX1][DW-1:0];
    assign par_op = (OP == LSX_ILOAD2) || (OP == LSX_ILOAD_ST) ||
                    (OP == LSX_FLOAD_ST);
    assign MEM_RADDR_A = par_op ?
        ind_addr(ADDR_A_BASE, ADDR_A_DISP, ir0_v, ir1_v) : ADDR_A_BASE;
    assign MEM_RADDR_B = ind_addr(ADDR_B_BASE, ADDR_B_DISP, ir0_v, ir1_v);

    // Source value by addressing mode.
    always_comb begin
        src_val = '0;
        unique case (SRC_MODE)
            AM_REG: src_val = regs_r[SRC_REG];
            AM_DIR, AM_IND: src_val = {{(XW-DW){1'b0}}, MEM_RDATA_A};
            AM_IMM: src_val = {{(XW-DW){1'b0}}, IMM};
        endcase
    end

    // Interlocked load refuses register and immediate sources.
    // Parallel forms refuse anything but indirect memory operands.
    assign src_bad = ((OP == LSX_ILOAD_I) &&
                      (SRC_MODE == AM_REG || SRC_MODE == AM_IMM)) ||
                     (par_op && SRC_MODE != AM_IND);

    lsx_shift u_shift (
        .value(regs_r[DST_REG][DW-1:0]),
        .count(src_val[DW-1:0]),
        .result(shift_res),
        .carry(shift_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // Execute state: one cycle per issued instruction.

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= ISSUE ? ST_EXEC : ST_IDLE;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            illegal_r <= 1'b0;
        end else begin
            illegal_r <= ISSUE && src_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes on the edge that starts the execute cycle.

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < REGS_N; i++) begin
                regs_r[i] <= '0;
            end
        end else if (ISSUE && !src_bad) begin
            unique case (OP)
                LSX_ILOAD, LSX_ILOAD_U, LSX_ILOAD_I: begin
                    // Any register, page pointer included.
                    regs_r[DST_REG] <= {regs_r[DST_REG][XW-1:DW],
                                        src_val[DW-1:0]};
                end
                LSX_ILOAD_C: begin
                    if (cond_true(COND, flags_r)) begin
                        regs_r[DST_REG] <= {regs_r[DST_REG][XW-1:DW],
                                            src_val[DW-1:0]};
                    end
                end
                LSX_ILOAD2: begin
                    // Same target: the DST2_REG write is skipped, so the B source value stands.
                    regs_r[DST_REG] <= {regs_r[DST_REG][XW-1:DW],
                                        MEM_RDATA_B};
                    if (DST2_REG != DST_REG) begin
                        regs_r[DST2_REG] <= {regs_r[DST2_REG][XW-1:DW],
                                             MEM_RDATA_A};
                    end
                end
                LSX_ILOAD_ST: begin
                    regs_r[DST_REG] <= {regs_r[DST_REG][XW-1:DW],
                                        src_val[DW-1:0]};
                end
                LSX_FLOAD_ST: begin
                    // Memory float word: exponent high, mantissa low.
                    regs_r[DST_REG] <= {src_val[DW-1:DW-FMAN_LO],
                                        src_val[DW-FMAN_LO-1:0],
                                        {FMAN_LO{1'b0}}};
                end
                LSX_MLOAD: begin
                    // A memory or immediate word holds its mantissa below
                    // the exponent byte, so only that part is taken.
                    if (SRC_MODE == AM_REG) begin
                        regs_r[DST_REG] <= {regs_r[DST_REG][EXP_HI:EXP_LO],
                                            src_val[MAN_HI:0]};
                    end else begin
                        regs_r[DST_REG] <= {regs_r[DST_REG][EXP_HI:EXP_LO],
                                            src_val[DW-FMAN_LO-1:0],
                                            {FMAN_LO{1'b0}}};
                    end
                end
                LSX_LSHIFT: begin
                    regs_r[DST_REG] <= {regs_r[DST_REG][XW-1:DW],
                                        shift_res};
                end
                LSX_NOP: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags.

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            flags_r <= '0;
        end else if (ISSUE && !src_bad) begin
            if (OP == LSX_ILOAD_I || OP == LSX_ILOAD) begin
                // N and Z follow the value, V and UF clear.
                flags_r[F_N] <= src_val[DW-1];
                flags_r[F_Z] <= (src_val[DW-1:0] == '0);
                flags_r[F_V] <= 1'b0;
                flags_r[F_UF] <= 1'b0;
            end else if (OP == LSX_LSHIFT) begin
                // Carry is the last bit out; N Z from result.
                flags_r[F_C] <= shift_c;
                flags_r[F_N] <= shift_res[DW-1];
                flags_r[F_Z] <= (shift_res == '0);
                flags_r[F_V] <= 1'b0;
                flags_r[F_UF] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Store path of the parallel forms.
    // The store data comes from the register before this cycle's load
    // writes it, and the load reads memory before the write lands.

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            we_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= '0;
        end else begin
            we_r <= ISSUE && !src_bad &&
                    (OP == LSX_ILOAD_ST || OP == LSX_FLOAD_ST);
            waddr_r <= MEM_RADDR_B;
            if (OP == LSX_FLOAD_ST) begin
                // Float store packs exponent and upper mantissa.
                wdata_r <= {regs_r[STORE_REG][EXP_HI:EXP_LO],
                            regs_r[STORE_REG][MAN_HI:FMAN_LO]};
            end else begin
                wdata_r <= regs_r[STORE_REG][DW-1:0];
            end
        end
    end

    // Interlock signalling on both flag pins for one cycle.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            xf_r <= 1'b0;
        end else begin
            xf_r <= ISSUE && !src_bad && (OP == LSX_ILOAD_I);
        end
    end

    assign MEM_WE = we_r;
    assign MEM_WADDR = waddr_r;
    assign MEM_WDATA = wdata_r;
    assign XFLAG0_O = xf_r;
    assign XFLAG0_OE = xf_r;
    assign XFLAG1_O = xf_r;
    assign XFLAG1_OE = xf_r;
    assign ILLEGAL = illegal_r;
    assign BUSY = (state_r == ST_EXEC);
    assign FLAGS = flags_r;
    assign DPAGE = regs_r[REG_DPAGE][DW-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_ilock_issue;
        ISSUE && !src_bad && OP == LSX_ILOAD_I;
    endsequence

    a_ilock_pins: assert property (@(posedge CLK) disable iff (!RST_B)
        s_ilock_issue |=> XFLAG0_OE && XFLAG1_OE)
        else $error("interlock pins not driven");
    a_ilock_mode: assert property (@(posedge CLK) disable iff (!RST_B)
        ISSUE && OP == LSX_ILOAD_I && SRC_MODE == AM_IMM |=> ILLEGAL)
        else $error("interlock immediate accepted");
    a_ilock_flags: assert property (@(posedge CLK) disable iff (!RST_B)
        s_ilock_issue |=> !FLAGS[F_V] && !FLAGS[F_UF] &&
        FLAGS[F_C] == $past(FLAGS[F_C]))
        else $error("interlock flags wrong");
    a_uload_flags: assert property (@(posedge CLK) disable iff (!RST_B)
        ISSUE && OP == LSX_ILOAD_U |=> $stable(FLAGS))
        else $error("unconditional load moved flags");
    a_shift_zero: assert property (@(posedge CLK) disable iff (!RST_B)
        ISSUE && !src_bad && OP == LSX_LSHIFT &&
        src_val[CNT_W-1:0] == '0 |=> !FLAGS[F_C])
        else $error("zero shift left carry set");
    a_shift_vuf: assert property (@(posedge CLK) disable iff (!RST_B)
        ISSUE && !src_bad && OP == LSX_LSHIFT |=>
        !FLAGS[F_V] && !FLAGS[F_UF])
        else $error("shift kept overflow");
    a_store_pulse: assert property (@(posedge CLK) disable iff (!RST_B)
        ISSUE && !src_bad && OP == LSX_ILOAD_ST |=> MEM_WE ##1
        (!MEM_WE || $past(ISSUE)))
        else $error("store pulse wrong");
    a_cond_false: assert property (@(posedge CLK) disable iff (!RST_B)
        ISSUE && OP == LSX_ILOAD_C && !cond_true(COND, flags_r) |=>
        regs_r[$past(DST_REG)] == $past(regs_r[DST_REG]))
        else $error("false condition wrote register");

endmodule : lsx_exec

// ===== lsx_mem_model.sv
// Data memory model standing at the far side of the execute block.
// Assumes word addresses whose low eight bits pick one of 256 words.
`timescale 1ns/100ps
module lsx_mem_model
    import lsx_pkg::*;
(
    input wire logic clk,
    input wire logic [DW-1:0] raddr_a,
    input wire logic [DW-1:0] raddr_b,
    input wire logic we,
    input wire logic [DW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata_a,
    output logic [DW-1:0] rdata_b
);
    logic [DW-1:0] mem [256];

    // Reads answer at once, so a load always sees the word before the store.
    assign rdata_a = mem[raddr_a[7:0]];
    assign rdata_b = mem[raddr_b[7:0]];

    // A write lands on the edge that closes the one-cycle write pulse.
    always @(posedge clk) begin
        if (we) begin
            mem[waddr[7:0]] <= wdata;
        end
    end
endmodule : lsx_mem_model

// ===== testbench.sv
// Self-checking bench for the load, store and shift execute block.
// Assumes the memory model answers reads at once and writes on MEM_WE.
`timescale 1ns/100ps
module testbench
    import lsx_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic issue = 1'b0;
    lsx_op_t op = LSX_NOP;
    logic [1:0] sm = 2'h0, da = 2'h0, db = 2'h0, g_da = 2'h0, g_db = 2'h0;
    logic [4:0] sr = 5'h00, dr = 5'h00, d2 = 5'h00, sto = 5'h00;
    logic [4:0] cn = 5'h00, g_d2 = 5'h00, g_st = 5'h00, g_cn = 5'h00;
    logic [31:0] imm = 32'h0, ab = 32'h0, bb = 32'h0;
    logic [31:0] raa, rab, rda, rdb, wa, wd, dp;
    logic we, x0, x0e, x1, x1e, ill, busy;
    logic [6:0] fl;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    lsx_exec dut_u (
        .CLK(clk), .RST_B(rst_b), .ISSUE(issue), .OP(op), .SRC_MODE(sm),
        .SRC_REG(sr), .DST_REG(dr), .DST2_REG(d2), .STORE_REG(sto),
        .COND(cn), .IMM(imm), .ADDR_A_BASE(ab), .ADDR_A_DISP(da),
        .ADDR_B_BASE(bb), .ADDR_B_DISP(db), .MEM_RDATA_A(rda),
        .MEM_RDATA_B(rdb), .MEM_RADDR_A(raa), .MEM_RADDR_B(rab),
        .MEM_WE(we), .MEM_WADDR(wa), .MEM_WDATA(wd), .XFLAG0_O(x0),
        .XFLAG0_OE(x0e), .XFLAG1_O(x1), .XFLAG1_OE(x1e), .ILLEGAL(ill),
        .BUSY(busy), .FLAGS(fl), .DPAGE(dp)
    );
    lsx_mem_model mem_u (
        .clk(clk), .raddr_a(raa), .raddr_b(rab), .we(we), .waddr(wa),
        .wdata(wd), .rdata_a(rda), .rdata_b(rdb)
    );

    // The clock and a cycle ceiling that cuts a hung run short.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end

    ////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(string nm, logic [39:0] e, logic [39:0] s);
        cmp_count++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            fail_count++;
        end
    endtask : chk

    // One issue edge, then settle just past the edge that shows the result.
    task automatic iss(lsx_op_t o, logic [1:0] m, logic [4:0] d,
                       logic [31:0] v, logic [31:0] a, logic [31:0] b);
        @(posedge clk);
        op <= o;
        sm <= m;
        dr <= d;
        imm <= v;
        sr <= v[4:0];
        ab <= a;
        bb <= b;
        da <= g_da;
        db <= g_db;
        d2 <= g_d2;
        sto <= g_st;
        cn <= g_cn;
        issue <= 1'b1;
        @(posedge clk);
        issue <= 1'b0;
        #1;
    endtask : iss

    // Registers other than the page pointer are visible only through the store half of a parallel op.
    task automatic rd(logic [4:0] r, logic [31:0] e, string nm);
        g_st = r;
        g_da = DISP_0;
        g_db = DISP_0;
        iss(LSX_ILOAD_ST, AM_IND, 5'h07, 32'h0, 32'h0, 32'hF0);
        chk(nm, e, wd);
    endtask : rd

    task automatic setf(logic [31:0] v, logic [31:0] n);
        iss(LSX_ILOAD, AM_IMM, 5'h06, v, 32'h0, 32'h0);
        iss(LSX_LSHIFT, AM_IMM, 5'h06, n, 32'h0, 32'h0);
    endtask : setf

    function automatic bit ctrue(int k, logic [6:0] f);
        logic [19:0] t;
        logic c, v, z, n, u;
        {u, n, z, v, c} = f[4:0];
        t = {z | u, f[6], ~f[6], f[5], ~f[5], u, ~u, v, ~v, ~n, ~n & ~z,
             n | z, n, ~z, z, ~c, ~c & ~z, c | z, c, 1'b1};
        return k < 20 ? t[k] : 1'b0;
    endfunction : ctrue

    ////////////////////////////////////////
    task automatic t_iload();
        mem_u.mem[8'h21] = 32'h00000080;
        iss(LSX_ILOAD, AM_IMM, 5'h03, 32'h80000000, 32'h0, 32'h0);
        chk("busy", 1'b1, busy);
        iss(LSX_ILOAD, AM_REG, 5'h05, 32'h3, 32'h0, 32'h0);
        iss(LSX_ILOAD, AM_DIR, REG_DPAGE, 32'h0, 32'h21, 32'h0);
        chk("page pointer", 32'h80, dp);
        rd(5'h05, 32'h80000000, "reg copy");
        setf(32'h80000000, 32'h1);
        iss(LSX_ILOAD_U, AM_IMM, 5'h05, 32'h0, 32'h0, 32'h0);
        chk("unc flags", 7'h05, fl);
        rd(5'h05, 32'h0, "unc dst");
    endtask : t_iload

    // Conditional loads under two flag states, every code plus one unused.
    task automatic t_cond();
        logic [31:0] r4;
        logic [6:0] f;
        for (int k = 0; k < 2; k++) begin
            iss(LSX_ILOAD, AM_IMM, 5'h04, 32'h0, 32'h0, 32'h0);
            r4 = 32'h0;
            setf(k ? 32'h40000000 : 32'h80000000, 32'h1);
            f = k ? 7'h08 : 7'h05;
            for (int c = 0; c < 21; c++) begin
                g_cn = 5'(c);
                iss(LSX_ILOAD_C, AM_IMM, 5'h04, 32'h100 + c, 32'h0, 32'h0);
                if (ctrue(c, f)) r4 = 32'h100 + c;
                rd(5'h04, r4, "cond dst");
            end
            chk("cond flags", f, fl);
        end
    endtask : t_cond

    task automatic t_shift();
        logic [31:0] v [6] = '{32'h80000001, 32'hF8, 32'h5, 32'h12C00000,
                               32'h2AC, 32'h1};
        logic [31:0] n [6] = '{32'h1, 32'h7C, 32'hFFFFFF80, 32'hFFFFFFF4,
                               32'h18, 32'h7F};
        logic [31:0] r [6] = '{32'h2, 32'hF, 32'h5, 32'h12C00,
                               32'hAC000000, 32'h0};
        logic [6:0] f [6] = '{7'h01, 7'h01, 7'h00, 7'h00, 7'h08, 7'h05};
        for (int i = 0; i < 6; i++) begin
            setf(v[i], n[i]);
            chk("shift flags", f[i], fl);
            rd(5'h06, r[i], "shift result");
        end
    endtask : t_shift

    task automatic t_lock();
        mem_u.mem[8'h22] = 32'h800000DC;
        setf(32'h80000000, 32'h1);
        iss(LSX_ILOAD_I, AM_DIR, 5'h03, 32'h0, 32'h22, 32'h0);
        chk("flag pins", 4'hF, {x0, x0e, x1, x1e});
        chk("lock flags", 7'h09, fl);
        chk("lock taken", 1'b0, ill);
        rd(5'h03, 32'h800000DC, "lock dst");
        chk("pins idle", 2'h0, {x0e, x1e});
        for (int k = 0; k < 2; k++) begin
            iss(LSX_ILOAD_I, k ? AM_IMM : AM_REG, 5'h03, 32'h5, 32'h22, 0);
            chk("lock refused", 1'b1, ill);
            chk("no pins", 2'h0, {x0e, x1e});
        end
        rd(5'h03, 32'h800000DC, "lock kept");
    endtask : t_lock

    // Parallel forms with every displacement and a shared memory word.
    task automatic t_par();
        iss(LSX_ILOAD, AM_IMM, REG_IDX0, 32'h4, 32'h0, 32'h0);
        iss(LSX_ILOAD, AM_IMM, REG_IDX1, 32'h8, 32'h0, 32'h0);
        mem_u.mem[8'h44] = 32'hA1A1A1A1;
        mem_u.mem[8'h51] = 32'hB1B1B1B1;
        mem_u.mem[8'h58] = 32'hB2B2B2B2;
        mem_u.mem[8'h70] = 32'h0000C0DE;
        g_da = DISP_IR0;
        g_db = DISP_1;
        g_d2 = 5'h02;
        iss(LSX_ILOAD2, AM_IND, 5'h01, 32'h0, 32'h40, 32'h50);
        rd(5'h02, 32'hA1A1A1A1, "dual a");
        rd(5'h01, 32'hB1B1B1B1, "dual b");
        g_da = DISP_1;
        g_db = DISP_IR1;
        g_d2 = 5'h01;
        iss(LSX_ILOAD2, AM_IND, 5'h01, 32'h0, 32'h40, 32'h50);
        rd(5'h01, 32'hB2B2B2B2, "dual same");
        iss(LSX_ILOAD2, AM_DIR, 5'h01, 32'h0, 32'h44, 32'h51);
        chk("dual refused", 1'b1, ill);
        rd(5'h01, 32'hB2B2B2B2, "dual kept");
        g_st = 5'h02;
        g_db = DISP_IR1;
        iss(LSX_ILOAD_ST, AM_IND, 5'h01, 32'h0, 32'h70, 32'h68);
        chk("store pulse", 1'b1, we);
        chk("store addr", 32'h70, wa);
        chk("store data", 32'hA1A1A1A1, wd);
        rd(5'h01, 32'h0000C0DE, "old word");
        chk("new word", 32'hA1A1A1A1, mem_u.mem[8'h70]);
    endtask : t_par

    task automatic t_flt();
        mem_u.mem[8'h80] = 32'h057B4000;
        mem_u.mem[8'h81] = 32'h0A123456;
        g_st = 5'h03;
        iss(LSX_FLOAD_ST, AM_IND, 5'h01, 32'h0, 32'h80, 32'h90);
        iss(LSX_MLOAD, AM_DIR, 5'h01, 32'h0, 32'h81, 32'h0);
        g_st = 5'h01;
        iss(LSX_FLOAD_ST, AM_IND, 5'h02, 32'h0, 32'h80, 32'h90);
        chk("float store", 32'h05123456, wd);
        rd(5'h02, 32'h7B400000, "float load");
    endtask : t_flt

    ////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem_u.mem[i] = 32'(i);
        end
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("reset flags", 7'h00, fl);
        t_iload();
        $display("iload done");
        t_cond();
        $display("cond done");
        t_shift();
        $display("shift done");
        t_lock();
        $display("lock done");
        t_par();
        $display("parallel done");
        t_flt();
        $display("float done");
        test_done();
    end
endmodule : testbench
